// [logic/eps_pkg.sv]
package eps_pkg;
	localparam int NUM_COS        = 8;
	localparam int PRIO_W         = 3;
	localparam int WGT_W          = 5;
	localparam int RATE_W         = 32;
	localparam int CREDIT_W       = 16;
	localparam int LEN_W          = 14;
	localparam int NUM_PPROF      = 9;
	localparam int NUM_WPROF      = 6;
	localparam int PPROF_W        = 4;
	localparam int WPROF_W        = 3;
	localparam logic [PRIO_W-1:0] PRIO_MAX = 3'h4;
	localparam logic [PRIO_W-1:0] PRIO_MIN = 3'h1;
	localparam logic [WGT_W-1:0]  WGT_MAX  = 5'h14;
	localparam logic [WGT_W-1:0]  WGT_MIN  = 5'h01;
	localparam logic [PPROF_W-1:0] PPROF_DEFAULT = 4'h9;
	localparam logic [PPROF_W-1:0] PPROF_USER_LAST = 4'h8;
	localparam logic [WPROF_W-1:0] WPROF_DEFAULT = 3'h1;
	localparam logic [WPROF_W-1:0] WPROF_USER_LAST = 3'h6;
	// Default committed priorities, CoS 7 in the top three bits.
	localparam logic [NUM_COS*PRIO_W-1:0] PRIO_DEFAULT = 24'h8DA491;
	// Fixed excess priorities: CoS 7 top, all others lowest.
	localparam logic [NUM_COS*PRIO_W-1:0] PRIO_EXCESS  = 24'h849249;
	localparam logic [PRIO_W-1:0] PRIO_RST = 3'h1;
	localparam logic [WGT_W-1:0]  WGT_RST  = 5'h14;
	localparam logic [31:0] ADDR_PPROF_SEL = 32'h0000_0000;
	localparam logic [31:0] ADDR_WPROF_SEL = 32'h0000_0004;
	localparam logic [31:0] ADDR_PPROF_BASE = 32'h0000_0100;
	localparam logic [31:0] ADDR_WPROF_BASE = 32'h0000_0400;
	localparam logic [31:0] ADDR_STATUS    = 32'h0000_0008;
	localparam logic [31:0] ADDR_CRATE     = 32'h0000_000C;
	localparam logic [31:0] ADDR_PRATE     = 32'h0000_0010;
	localparam logic [31:0] ADDR_MAP_END   = 32'h0000_0500;
	// Each profile takes 32 bytes, so its eight CoS words never reach the next profile.
	localparam int PROF_STRIDE_SHIFT = 5;
	localparam int ROW_WGT_SHIFT = 8;
endpackage

// [logic/eps_arbiter.sv]
module eps_arbiter (
	input  wire logic [eps_pkg::NUM_COS*eps_pkg::PRIO_W-1:0] prio_vec,
	input  wire logic [eps_pkg::NUM_COS-1:0]                 ready_vec,
	input  wire logic [eps_pkg::NUM_COS-1:0]                 credit_ok,
	input  wire logic [2:0]                                  rr_ptr,
	output logic                                             grant_valid,
	output logic      [2:0]                                  grant_cos,
	output logic                                             grant_had_credit
);
	logic [eps_pkg::PRIO_W-1:0] best;
	logic [eps_pkg::NUM_COS-1:0] top;
	logic                        any_cred;
	logic [2:0]                  idx;

	always_comb
	begin
		best = '0;
		top = '0;
		any_cred = 1'b0;
		grant_valid = 1'b0;
		grant_cos = 3'h0;
		grant_had_credit = 1'b0;
		idx = 3'h0;
		for (int i = 0; i < eps_pkg::NUM_COS; i++)
			if (ready_vec[i] && prio_vec[i*eps_pkg::PRIO_W +: eps_pkg::PRIO_W] > best)
				best = prio_vec[i*eps_pkg::PRIO_W +: eps_pkg::PRIO_W];
		for (int i = 0; i < eps_pkg::NUM_COS; i++)
			top[i] = ready_vec[i] && (prio_vec[i*eps_pkg::PRIO_W +: eps_pkg::PRIO_W] == best);
		any_cred = |(top & credit_ok);
		for (int k = eps_pkg::NUM_COS - 1; k >= 0; k--)
		begin
			idx = rr_ptr + 3'(k);
			if (top[idx] && (credit_ok[idx] || !any_cred))
			begin
				grant_valid = 1'b1;
				grant_cos = idx;
				grant_had_credit = any_cred;
			end
		end
	end
endmodule // eps_arbiter

// [logic/eps_sched.sv]
// Functional notes
// - Bundle committed below rate, excess above
// - Committed uses profile, excess uses fixed
// - Four priority levels, 4 highest
// - CoS 7 always highest level
// - Excess priorities fixed: 1, CoS7 4
// - Nine priority profiles, ninth read-only
// - Default profile priorities 1,2,2,2,2,3,3,4
// - One priority profile per interface
// - Interface defaults to priority profile 9
// - Profile holds one priority per CoS
// - Strict priority, ties by fair queuing
// - Byte weights 1 to 20 per CoS
// - Six weight profiles, first read-only
// - Default weights all 20, both states
// - One weight profile, default profile 1
// - Above peak rate, bundle stops
// - Queue chosen by ingress CoS
module eps_sched (
	input  wire logic                                    clk_sys,
	input  wire logic                                    rstn,
	input  wire logic                                    clk_en,
	input  wire logic                                    psel,
	input  wire logic                                    penable,
	input  wire logic                                    pwrite,
	input  wire logic [31:0]                             paddr,
	input  wire logic [31:0]                             pwdata,
	output logic      [31:0]                             prdata,
	output logic                                         pready,
	output logic                                         pslverr,
	input  wire logic [eps_pkg::RATE_W-1:0]              bundle_rate,
	input  wire logic [eps_pkg::NUM_COS-1:0]             queue_ready,
	input  wire logic [eps_pkg::LEN_W-1:0]               head_len,
	input  wire logic [2:0]                              ingress_cos,
	output logic      [2:0]                              enq_queue,
	input  wire logic                                    tx_ready,
	output logic                                         tx_valid,
	output logic      [2:0]                              tx_cos,
	output logic                                         bundle_excess,
	output logic                                         bundle_stopped
);
	localparam int NC = eps_pkg::NUM_COS;
	localparam int PW = eps_pkg::PRIO_W;
	localparam int WW = eps_pkg::WGT_W;

	logic [NC*PW-1:0]             prio_tbl [eps_pkg::NUM_PPROF];
	logic [WW-1:0]                wgt_tbl  [eps_pkg::NUM_WPROF][NC];
	logic [eps_pkg::PPROF_W-1:0]  pprof_sel;
	logic [eps_pkg::WPROF_W-1:0]  wprof_sel;
	logic [eps_pkg::RATE_W-1:0]   committed_rate;
	logic [eps_pkg::RATE_W-1:0]   peak_rate;
	logic signed [eps_pkg::CREDIT_W-1:0] credit [NC];
	logic [NC-1:0]                credit_ok;
	logic [2:0]                   rr_ptr;
	logic [NC*PW-1:0]             prio_vec;
	logic                         grant_valid;
	logic [2:0]                   grant_cos;
	logic                         grant_had_credit;
	logic                         wr_en;
	logic                         rd_en;
	logic [3:0]                   p_idx;
	logic [2:0]                   w_idx;
	logic [2:0]                   c_idx;

	// Decodes a profile-table address into profile and CoS index.
	function automatic logic [6:0] prof_decode(input logic [31:0] a, input logic [31:0] base);
		logic [31:0] off;
		off = a - base;
		prof_decode = {off[eps_pkg::PROF_STRIDE_SHIFT+3:eps_pkg::PROF_STRIDE_SHIFT],
			off[4:2]};
	endfunction

	// Clamps a priority into the legal 1..4 range.
	function automatic logic [PW-1:0] clamp_prio(input logic [PW-1:0] v);
		if (v > eps_pkg::PRIO_MAX)
			clamp_prio = eps_pkg::PRIO_MAX;
		else if (v < eps_pkg::PRIO_MIN)
			clamp_prio = eps_pkg::PRIO_MIN;
		else
			clamp_prio = v;
	endfunction

	assign wr_en = psel && penable && pwrite && clk_en;
	assign rd_en = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign {p_idx, c_idx} = prof_decode(paddr, eps_pkg::ADDR_PPROF_BASE);
	assign w_idx = 3'(prof_decode(paddr, eps_pkg::ADDR_WPROF_BASE) >> 3);

	assign bundle_excess  = !(bundle_rate < committed_rate);
	assign bundle_stopped = !(bundle_rate < peak_rate);

	assign enq_queue = ingress_cos;

	assign prio_vec = bundle_excess ? eps_pkg::PRIO_EXCESS : prio_tbl[pprof_sel - 4'h1];

	genvar g;
	generate
		for (g = 0; g < NC; g++)
		begin : g_credit
			assign credit_ok[g] = credit[g] > 0;
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			pprof_sel <= eps_pkg::PPROF_DEFAULT;
		else if (wr_en && paddr == eps_pkg::ADDR_PPROF_SEL && pwdata[3:0] >= 4'h1
			&& pwdata[3:0] <= eps_pkg::PPROF_DEFAULT)
			pprof_sel <= pwdata[3:0];
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			wprof_sel <= eps_pkg::WPROF_DEFAULT;
		else if (wr_en && paddr == eps_pkg::ADDR_WPROF_SEL
			&& pwdata[2:0] >= eps_pkg::WPROF_DEFAULT
			&& pwdata[2:0] <= eps_pkg::WPROF_USER_LAST)
			wprof_sel <= pwdata[2:0];
	end

	// A zero threshold after reset puts the bundle in excess state until software sets it.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			committed_rate <= '0;
		else if (wr_en && paddr == eps_pkg::ADDR_CRATE)
			committed_rate <= pwdata;
	end

	// An all-ones peak keeps the bundle running until a real limit is written.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			peak_rate <= '1;
		else if (wr_en && paddr == eps_pkg::ADDR_PRATE)
			peak_rate <= pwdata;
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int p = 0; p < eps_pkg::NUM_PPROF; p++)
				prio_tbl[p] <= eps_pkg::PRIO_DEFAULT;
		end
		else if (wr_en && paddr >= eps_pkg::ADDR_PPROF_BASE && paddr < eps_pkg::ADDR_WPROF_BASE
			&& p_idx >= 4'h1 && p_idx <= eps_pkg::PPROF_USER_LAST && c_idx != 3'h7)
			prio_tbl[p_idx - 4'h1][c_idx*PW +: PW] <= clamp_prio(pwdata[PW-1:0]);
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int p = 0; p < eps_pkg::NUM_WPROF; p++)
				for (int c = 0; c < NC; c++)
					wgt_tbl[p][c] <= eps_pkg::WGT_RST;
		end
		else if (wr_en && paddr >= eps_pkg::ADDR_WPROF_BASE && paddr < eps_pkg::ADDR_MAP_END
			&& w_idx > eps_pkg::WPROF_DEFAULT && w_idx <= eps_pkg::WPROF_USER_LAST
			&& pwdata[WW-1:0] >= eps_pkg::WGT_MIN && pwdata[WW-1:0] <= eps_pkg::WGT_MAX)
			wgt_tbl[w_idx - 3'h1][c_idx] <= pwdata[WW-1:0];
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			prdata <= '0;
		else if (psel && !penable && clk_en)
		begin
			prdata <= '0;
			if (paddr == eps_pkg::ADDR_PPROF_SEL)
				prdata <= {28'h0000000, pprof_sel};
			else if (paddr == eps_pkg::ADDR_WPROF_SEL)
				prdata <= {29'h0, wprof_sel};
			else if (paddr == eps_pkg::ADDR_STATUS)
				prdata <= {30'h0, bundle_stopped, bundle_excess};
			else if (paddr == eps_pkg::ADDR_CRATE)
				prdata <= committed_rate;
			else if (paddr == eps_pkg::ADDR_PRATE)
				prdata <= peak_rate;
			else if (paddr >= eps_pkg::ADDR_PPROF_BASE && paddr < eps_pkg::ADDR_WPROF_BASE
				&& p_idx >= 4'h1 && p_idx <= eps_pkg::PPROF_DEFAULT)
				prdata <= {29'h0, prio_tbl[p_idx - 4'h1][c_idx*PW +: PW]};
			else if (paddr >= eps_pkg::ADDR_WPROF_BASE && paddr < eps_pkg::ADDR_MAP_END
				&& w_idx >= eps_pkg::WPROF_DEFAULT && w_idx <= eps_pkg::WPROF_USER_LAST)
				prdata <= {27'h0, wgt_tbl[w_idx - 3'h1][c_idx]};
		end
	end

	// Reads are decoded in the setup cycle so data comes from a flop with zero wait states.
	always_comb
	begin
		pslverr = 1'b0;
		if (psel && penable && !pwrite && rd_en)
			pslverr = !(paddr == eps_pkg::ADDR_PPROF_SEL || paddr == eps_pkg::ADDR_WPROF_SEL
				|| paddr == eps_pkg::ADDR_STATUS || paddr == eps_pkg::ADDR_CRATE
				|| paddr == eps_pkg::ADDR_PRATE
				|| (paddr >= eps_pkg::ADDR_PPROF_BASE && paddr < eps_pkg::ADDR_MAP_END));
	end

	eps_arbiter u_arb (
		.prio_vec         (prio_vec),
		.ready_vec        (queue_ready & {NC{!bundle_stopped}}),
		.credit_ok        (credit_ok),
		.rr_ptr           (rr_ptr),
		.grant_valid      (grant_valid),
		.grant_cos        (grant_cos),
		.grant_had_credit (grant_had_credit)
	);

	assign tx_valid = grant_valid;
	assign tx_cos   = grant_cos;

	// Starting the search past the last served queue keeps ties from starving.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			rr_ptr <= 3'h0;
		else if (clk_en && grant_valid && tx_ready)
			rr_ptr <= grant_cos + 3'h1;
	end

	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int c = 0; c < NC; c++)
				credit[c] <= '0;
		end
		else if (clk_en && grant_valid && tx_ready)
		begin
			for (int c = 0; c < NC; c++)
			begin
				if (!grant_had_credit && prio_vec[c*PW +: PW] == prio_vec[grant_cos*PW +: PW])
					credit[c] <= eps_pkg::CREDIT_W'(wgt_tbl[wprof_sel - 3'h1][c])
						- ((c == int'(grant_cos)) ? eps_pkg::CREDIT_W'(head_len) : '0);
				else if (c == int'(grant_cos))
					credit[c] <= credit[c] - eps_pkg::CREDIT_W'(head_len);
			end
		end
	end
endmodule // eps_sched

// [verification/eps_sched_asserts.sv]
module eps_sched_asserts (
	input wire logic        clk_sys,
	input wire logic        rstn,
	input wire logic        clk_en,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] bundle_rate,
	input wire logic [7:0]  queue_ready,
	input wire logic [2:0]  ingress_cos,
	input wire logic [2:0]  enq_queue,
	input wire logic        tx_ready,
	input wire logic        tx_valid,
	input wire logic [2:0]  tx_cos,
	input wire logic        bundle_excess,
	input wire logic        bundle_stopped
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] crate;
	logic [31:0] prate;
	logic        wr_en;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	assign wr_en = psel && penable && pwrite && clk_en;
	// Shadow copies of the rate thresholds, so the flags can be judged from the ports alone.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			crate <= 32'h0;
		else if (wr_en && paddr == eps_pkg::ADDR_CRATE)
			crate <= pwdata;
	end
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
			prate <= 32'hFFFFFFFF;
		else if (wr_en && paddr == eps_pkg::ADDR_PRATE)
			prate <= pwdata;
	end
	a_enq_map: assert property (enq_queue == ingress_cos)
		else $error("enqueue queue differs from ingress class");
	a_stop_idle: assert property (bundle_stopped |-> !tx_valid)
		else $error("transmit offered while bundle stopped");
	a_grant_data: assert property (tx_valid |-> queue_ready[tx_cos])
		else $error("granted queue holds no data");
	a_idle_empty: assert property (queue_ready == 8'h00 |-> !tx_valid)
		else $error("transmit offered with all queues empty");
	a_top_cos: assert property (queue_ready[7] && !bundle_stopped |-> tx_valid && tx_cos == 3'h7)
		else $error("class seven not served first");
	a_excess_flag: assert property (bundle_excess == (bundle_rate >= crate))
		else $error("excess flag wrong for rate");
	a_stop_flag: assert property (bundle_stopped == (bundle_rate >= prate))
		else $error("stop flag wrong for rate");
	a_hold_grant: assert property ((tx_valid && !tx_ready && !psel) ##1 (!psel && $stable(queue_ready)
		&& $stable(bundle_rate)) |-> $stable(tx_cos))
		else $error("grant moved without a transfer");
endmodule // eps_sched_asserts
bind eps_sched eps_sched_asserts u_chk (.clk_sys, .rstn, .clk_en, .psel, .penable, .pwrite,
	.paddr, .pwdata, .bundle_rate, .queue_ready, .ingress_cos, .enq_queue, .tx_ready, .tx_valid,
	.tx_cos, .bundle_excess, .bundle_stopped);

// [verification/eps_tx_sink.sv]
module eps_tx_sink (
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic go,
	input  wire logic slow,
	output logic      tx_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic phase;
	// Slow mode takes a frame only every other cycle, like a busy line.
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			phase    <= 1'b0;
			tx_ready <= 1'b0;
		end
		else
		begin
			phase    <= go ? !phase : 1'b0;
			tx_ready <= go && (!slow || !phase);
		end
	end
endmodule // eps_tx_sink

// [verification/tb_top.sv]
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, bundle_rate = 32'h0;
	logic [7:0]  queue_ready = 8'h00;
	logic [13:0] head_len = 14'h0001;
	logic [2:0]  ingress_cos = 3'h0, enq_queue, tx_cos;
	logic pready, pslverr, tx_ready, tx_valid, bundle_excess, bundle_stopped;
	logic go = 1'b0, slow = 1'b0, clk_en = 1'b1;
	localparam logic [31:0] PB = eps_pkg::ADDR_PPROF_BASE;
	localparam logic [31:0] WB = eps_pkg::ADDR_WPROF_BASE;
	int miscompares = 0, checks_done = 0;
	always #2 clk_sys = !clk_sys;
	eps_sched dut (.clk_sys, .rstn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .bundle_rate, .queue_ready, .head_len, .ingress_cos,
		.enq_queue, .tx_ready, .tx_valid, .tx_cos, .bundle_excess, .bundle_stopped);
	eps_tx_sink u_sink (.clk_sys, .rstn, .go, .slow, .tx_ready);
	function automatic logic [31:0] pa(input logic [31:0] b, input int p, input int c);
		pa = b + 32'(p << eps_pkg::PROF_STRIDE_SHIFT) + 32'(c * 4);
	endfunction
	task automatic cmp_word(input logic [31:0] g, input logic [31:0] x);
		checks_done++;
		if (g !== x)
		begin
			miscompares++;
			$display("ERROR t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clk_sys);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		cmp_word(q, x);
		cmp_word({31'h0, e}, {31'h0, xe});
	endtask
	task automatic offer(input logic [31:0] r, input logic [7:0] qr);
		@(posedge clk_sys);
		bundle_rate <= r;
		queue_ready <= qr;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic t_defaults;
		logic [31:0] pd [8] = '{32'h1, 32'h2, 32'h2, 32'h2, 32'h2, 32'h3, 32'h3, 32'h4};
		rd(32'h0, 32'h9, 1'b0);
		rd(32'h4, 32'h1, 1'b0);
		for (int c = 0; c < 8; c++)
		begin
			rd(pa(PB, 9, c), pd[c], 1'b0);
			rd(pa(WB, 1, c), 32'h14, 1'b0);
		end
		wr(pa(PB, 9, 0), 32'h3);
		rd(pa(PB, 9, 0), 32'h1, 1'b0);
		wr(pa(WB, 1, 0), 32'h5);
		rd(pa(WB, 1, 0), 32'h14, 1'b0);
		wr(32'h0, 32'hA);
		rd(32'h0, 32'h9, 1'b0);
		clk_en <= 1'b0;
		wr(32'h0, 32'h1);
		clk_en <= 1'b1;
		rd(32'h0, 32'h9, 1'b0);
		rd(32'h40, 32'h0, 1'b1);
	endtask
	task automatic t_prio;
		wr(32'hC, 32'h3E8);
		wr(32'h10, 32'h7D0);
		offer(32'h1F4, 8'h7F);
		cmp_word({31'h0, tx_valid && (tx_cos === 3'h5 || tx_cos === 3'h6)}, 32'h1);
		rd(32'h8, 32'h0, 1'b0);
		offer(32'h1F4, 8'hFF);
		cmp_word({29'h0, tx_cos}, 32'h7);
		offer(32'h3E8, 8'h7F);
		rd(32'h8, 32'h1, 1'b0);
		offer(32'h7D0, 8'hFF);
		rd(32'h8, 32'h3, 1'b0);
		cmp_word({31'h0, tx_valid}, 32'h0);
		ingress_cos <= 3'h5;
		@(posedge clk_sys);
		#1;
		cmp_word({29'h0, enq_queue}, 32'h5);
	endtask
	task automatic t_user;
		wr(32'h0, 32'h1);
		wr(pa(PB, 1, 0), 32'h4);
		wr(pa(PB, 1, 7), 32'h1);
		rd(pa(PB, 1, 7), 32'h4, 1'b0);
		offer(32'h1F4, 8'h7F);
		cmp_word({29'h0, tx_cos}, 32'h0);
		offer(32'h3E8, 8'h81);
		cmp_word({29'h0, tx_cos}, 32'h7);
		wr(32'h0, 32'h9);
	endtask
	task automatic t_wfq;
		int n, c1;
		n = 0;
		c1 = 0;
		wr(32'h4, 32'h2);
		wr(pa(WB, 2, 1), 32'h14);
		wr(pa(WB, 2, 2), 32'h5);
		wr(pa(WB, 2, 2), 32'h15);
		rd(pa(WB, 2, 2), 32'h5, 1'b0);
		offer(32'h1F4, 8'h06);
		@(posedge clk_sys);
		go   <= 1'b1;
		slow <= 1'b1;
		repeat (200)
		begin
			@(posedge clk_sys);
			if (tx_valid === 1'b1 && tx_ready === 1'b1)
			begin
				n++;
				c1 += (tx_cos === 3'h1);
			end
		end
		go <= 1'b0;
		cmp_word(n, 32'd100);
		// Start-up credit is not pinned down, so allow a few frames of slack.
		cmp_word({31'h0, c1 >= 75 && c1 <= 85}, 32'h1);
	endtask
	task automatic final_report;
		$display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		#80000;
		miscompares++;
		final_report();
	end
	initial
	begin
		repeat (6) @(posedge clk_sys);
		rstn <= 1'b1;
		t_defaults();
		t_prio();
		t_user();
		t_wfq();
		final_report();
	end
endmodule // tb_top
